// *** verilog/dac_word_pkg.sv ***
// Package for the dual converter serial word: frame layout, targets, channels, coding.
// Assumes a 50 MHz system clock on both ends and a host-made serial clock.
package dac_word_pkg;
  localparam int FRAME_BITS = 24;
  localparam int DATA_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int CNT_BITS = 5;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  // Field positions, most significant end first
  localparam int POS_RW = 23;
  localparam int POS_ZERO = 22;
  localparam int POS_REG_HI = 21;
  localparam int POS_REG_LO = 19;
  localparam int POS_CH_HI = 18;
  localparam int POS_CH_LO = 16;
  localparam int POS_CODE_HI = 15;
  localparam int POS_CODE_LO = 4;
  localparam int POS_RANGE_HI = 2;
  localparam int POS_CODE_MSB = 11;
  // Target select values
  localparam logic [2:0] TGT_DATA = 3'h0;
  localparam logic [2:0] TGT_RANGE = 3'h1;
  localparam logic [2:0] TGT_POWER = 3'h2;
  localparam logic [2:0] TGT_CONTROL = 3'h3;
  // Channel select values
  localparam logic [2:0] CH_A = 3'h0;
  localparam logic [2:0] CH_B = 3'h2;
  localparam logic [2:0] CH_BOTH = 3'h4;
  // Range codes of three and above are bipolar spans
  localparam logic [2:0] RANGE_FIRST_BIPOLAR = 3'h3;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [11:0] CODE_MID = 12'h800;
  // Host serial clock divider: half period in system clocks (160 ns period)
  localparam int SCLK_HALF = 4;
  localparam logic [2:0] SCLK_HALF_LAST = 3'h3;
  // APB register offsets of the host controller
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RDATA = 8'h08;
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_LOW = 2'b01, H_HIGH = 2'b11} host_state_type;
endpackage

// *** verilog/dac_link_if.sv ***
// Serial link between the host controller and the converter device.
// Assumes both ends run on their own system clock; the host makes the link clock.
interface dac_link_if;
  logic sclk;
  logic sync_n;
  logic serial_data_input;
  logic sdo;
  modport host (output sclk, output sync_n, output serial_data_input, input sdo);
  modport device (input sclk, input sync_n, input serial_data_input, output sdo);
endinterface

// *** verilog/dac_word_device.sv ***
// Device end: 24-bit input shift register, register targets with readback, code decode.
// Assumes the host frames each word with sync_n low and changes data on sclk rising.
module dac_word_device
  import dac_word_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  dac_link_if.device link,
  input wire logic i_coding_select_pin,
  output logic [11:0] o_code_a,
  output logic [11:0] o_code_b,
  output logic o_bipolar_a,
  output logic o_bipolar_b,
  output logic [2:0] o_range_a,
  output logic [2:0] o_range_b,
  output logic [15:0] o_power,
  output logic [15:0] o_control,
  output logic o_word_done
);
  // Two-stage synchronisers on every link input
  logic [2:0] meta_q, sync_q, prev_q;
  logic coding_meta_q, coding_q;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= 3'h7;
      sync_q <= 3'h7;
      prev_q <= 3'h7;
      coding_meta_q <= 1'b0;
      coding_q <= 1'b0;
    end else begin
      meta_q <= {link.sclk, link.sync_n, link.serial_data_input};
      sync_q <= meta_q;
      prev_q <= sync_q;
      coding_meta_q <= i_coding_select_pin;
      coding_q <= coding_meta_q;
    end
  end
  logic sclk_fall, sclk_rise, frame_on;
  logic frame_start;
  // Frame line just went low; the clock is still high then
  assign frame_start = prev_q[1] & ~sync_q[1];
  assign sclk_fall = prev_q[2] & ~sync_q[2];
  assign sclk_rise = ~prev_q[2] & sync_q[2];
  assign frame_on = ~sync_q[1];

  logic [23:0] shift_q, shift_d, out_q, out_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] dat_a_q, dat_a_d, dat_b_q, dat_b_d, pwr_q, pwr_d, ctl_q, ctl_d;
  logic [2:0] rng_a_q, rng_a_d, rng_b_q, rng_b_d;
  logic done_q, done_d, sdo_q, sdo_d;
  logic [15:0] rd_val;
  logic [2:0] tgt, chn;
  assign tgt = shift_d[POS_REG_HI:POS_REG_LO];
  assign chn = shift_d[POS_CH_HI:POS_CH_LO];

  // Readback value chosen by the word that just completed
  always_comb begin
    rd_val = DATA_RESET;
    case (tgt)
      TGT_DATA: rd_val = (chn == CH_B) ? dat_b_q : dat_a_q;
      TGT_RANGE: rd_val = {13'h0000, (chn == CH_B) ? rng_b_q : rng_a_q};
      TGT_POWER: rd_val = pwr_q;
      TGT_CONTROL: rd_val = ctl_q;
      default: rd_val = DATA_RESET;
    endcase
  end

  // Shift in on falling sclk inside a frame; act on the 24th bit
  always_comb begin
    shift_d = shift_q;
    cnt_d = cnt_q;
    out_d = out_q;
    dat_a_d = dat_a_q;
    dat_b_d = dat_b_q;
    rng_a_d = rng_a_q;
    rng_b_d = rng_b_q;
    pwr_d = pwr_q;
    ctl_d = ctl_q;
    done_d = 1'b0;
    sdo_d = sdo_q;
    if (!frame_on) begin
      cnt_d = '0;
    end else if (frame_start) begin
      // First readback bit leaves as the frame opens: the host samples at its rise,
      // a full round trip after the bit was put out, so nothing arrives one bit late
      sdo_d = out_q[FRAME_BITS-1];
      out_d = {out_q[FRAME_BITS-2:0], 1'b0};
    end else if (sclk_fall) begin
      shift_d = {shift_q[FRAME_BITS-2:0], sync_q[0]};
      cnt_d = cnt_q + 5'h01;
      if (cnt_q == FRAME_LAST) begin
        cnt_d = '0;
        done_d = 1'b1;
        if (shift_d[POS_RW]) begin
          // Readback word shifts out during the following frame
          out_d = {shift_d[FRAME_BITS-1:DATA_BITS], rd_val};
        end else begin
          case (tgt)
            TGT_DATA: begin
              if (chn == CH_A || chn == CH_BOTH) dat_a_d = shift_d[DATA_BITS-1:0];
              if (chn == CH_B || chn == CH_BOTH) dat_b_d = shift_d[DATA_BITS-1:0];
            end
            TGT_RANGE: begin
              if (chn == CH_A || chn == CH_BOTH) rng_a_d = shift_d[POS_RANGE_HI:0];
              if (chn == CH_B || chn == CH_BOTH) rng_b_d = shift_d[POS_RANGE_HI:0];
            end
            TGT_POWER: pwr_d = shift_d[DATA_BITS-1:0];
            TGT_CONTROL: ctl_d = shift_d[DATA_BITS-1:0];
            default: ;
          endcase
        end
      end
    end else if (sclk_rise) begin
      sdo_d = out_q[FRAME_BITS-1];
      out_d = {out_q[FRAME_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      shift_q <= '0;
      cnt_q <= '0;
      out_q <= '0;
      dat_a_q <= DATA_RESET;
      dat_b_q <= DATA_RESET;
      rng_a_q <= '0;
      rng_b_q <= '0;
      pwr_q <= DATA_RESET;
      ctl_q <= DATA_RESET;
      done_q <= 1'b0;
      sdo_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      dat_a_q <= dat_a_d;
      dat_b_q <= dat_b_d;
      rng_a_q <= rng_a_d;
      rng_b_q <= rng_b_d;
      pwr_q <= pwr_d;
      ctl_q <= ctl_d;
      done_q <= done_d;
      sdo_q <= sdo_d;
    end
  end
  assign link.sdo = sdo_q;

  // Converter code: bits 15..4, low four ignored; normalised to offset binary
  function automatic logic [11:0] to_offset(input logic [15:0] d, input logic bip,
                                           input logic twos);
    logic [11:0] c;
    c = d[POS_CODE_HI:POS_CODE_LO];
    if (bip && twos) c[POS_CODE_MSB] = ~c[POS_CODE_MSB];
    return c;
  endfunction

  logic [11:0] code_a_q, code_b_q;
  logic bip_a_q, bip_b_q;
  logic bip_a, bip_b;
  assign bip_a = (rng_a_q >= RANGE_FIRST_BIPOLAR);
  assign bip_b = (rng_b_q >= RANGE_FIRST_BIPOLAR);
  // Registered so outputs come from flops; unipolar ignores the coding pin
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      code_a_q <= '0;
      code_b_q <= '0;
      bip_a_q <= 1'b0;
      bip_b_q <= 1'b0;
    end else begin
      code_a_q <= to_offset(dat_a_q, bip_a, ~coding_q);
      code_b_q <= to_offset(dat_b_q, bip_b, ~coding_q);
      bip_a_q <= bip_a;
      bip_b_q <= bip_b;
    end
  end
  assign o_code_a = code_a_q;
  assign o_code_b = code_b_q;
  assign o_bipolar_a = bip_a_q;
  assign o_bipolar_b = bip_b_q;
  assign o_range_a = rng_a_q;
  assign o_range_b = rng_b_q;
  assign o_power = pwr_q;
  assign o_control = ctl_q;
  assign o_word_done = done_q;
endmodule

// *** verilog/dac_word_host.sv ***
// Host end: APB slave holding a command word; sends 24-bit frames, captures readback.
// Assumes APB on i_clock; the device samples data on falling sclk.
//
// Our own choices: the APB register port and the register addresses.
module dac_word_host
  import dac_word_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  dac_link_if.host link,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  // Frame engine state, bit counter and link clock divider
  host_state_type st_q;
  host_state_type st_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [2:0] div_q;
  logic [2:0] div_d;
  // Outgoing word, bits gathered from the readback pin, last readback word
  logic [23:0] sh_q;
  logic [23:0] sh_d;
  logic [23:0] rx_q;
  logic [23:0] rx_d;
  logic [23:0] rd_q;
  logic [23:0] rd_d;
  // Link pins held in flops so nothing combinational reaches the wires
  logic sclk_q;
  logic sclk_d;
  logic sync_n_q;
  logic sync_n_d;
  logic sdi_q;
  logic sdi_d;
  logic busy_q;
  logic busy_d;
  // Register bus answer
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  // Readback pin after its two synchroniser flops
  logic sdo_meta_q;
  logic sdo_q;
  // Access phase seen, and a command write that completes on this edge
  logic acc;
  logic wr_cmd;

  // Readback pin passes two flops before use
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      sdo_meta_q <= 1'b0;
      sdo_q <= 1'b0;
    end else begin
      sdo_meta_q <= link.sdo;
      sdo_q <= sdo_meta_q;
    end
  end

  // A command write lands on the edge that completes the transfer, when pready is seen
  assign acc = i_psel & i_penable & ~pready_q;
  assign wr_cmd = i_psel & i_penable & pready_q & i_pwrite & (i_paddr == OFF_CMD) & ~busy_q;

  // APB slave: one wait state, answer on the second access cycle
  always_comb begin
    pready_d = acc;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (acc) begin
      prdata_d = '0;
      if (i_pwrite) begin
        if (i_paddr != OFF_CMD) pslverr_d = 1'b1;
      end else begin
        case (i_paddr)
          OFF_CMD: prdata_d = {8'h00, sh_q};
          OFF_STATUS: prdata_d = {31'h00000000, busy_q};
          OFF_RDATA: prdata_d = {8'h00, rd_q};
          default: pslverr_d = 1'b1;
        endcase
      end
    end
  end

  // Frame engine: sclk period is two half periods of SCLK_HALF clocks
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    rx_d = rx_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    div_d = div_q;
    sclk_d = sclk_q;
    sync_n_d = sync_n_q;
    sdi_d = sdi_q;
    busy_d = busy_q;
    case (st_q)
      // Idle: link clock parked high, frame line high
      H_IDLE: begin
        sclk_d = 1'b1;
        sync_n_d = 1'b1;
        if (wr_cmd) begin
          sh_d = i_pwdata[FRAME_BITS-1:0];
          // Software cannot put a one in the reserved position
          sh_d[POS_ZERO] = 1'b0;
          sdi_d = i_pwdata[POS_RW];
          sync_n_d = 1'b0;
          busy_d = 1'b1;
          cnt_d = '0;
          div_d = '0;
          st_d = H_HIGH;
        end
      end
      // First half of each bit: clock high, data already on the wire
      H_HIGH: begin
        div_d = div_q + 3'h1;
        if (div_q == SCLK_HALF_LAST) begin
          div_d = '0;
          sclk_d = 1'b0;
          st_d = H_LOW;
        end
      end
      // Second half: the device samples at the fall; the rise ends the bit
      H_LOW: begin
        div_d = div_q + 3'h1;
        if (div_q == SCLK_HALF_LAST) begin
          div_d = '0;
          sclk_d = 1'b1;
          rx_d = {rx_q[FRAME_BITS-2:0], sdo_q};
          if (cnt_q == FRAME_LAST) begin
            sync_n_d = 1'b1;
            busy_d = 1'b0;
            rd_d = {rx_q[FRAME_BITS-2:0], sdo_q};
            st_d = H_IDLE;
          end else begin
            cnt_d = cnt_q + 5'h01;
            // Next bit, counted down from the top of the word
            sdi_d = sh_q[POS_RW - 5'(cnt_q) - 1];
            st_d = H_HIGH;
          end
        end
      end
      default: st_d = H_IDLE;
    endcase
  end

  // Frame engine registers
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      st_q <= H_IDLE;
      sh_q <= '0;
      rx_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      div_q <= '0;
      sclk_q <= 1'b1;
      sync_n_q <= 1'b1;
      sdi_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      sclk_q <= sclk_d;
      sync_n_q <= sync_n_d;
      sdi_q <= sdi_d;
      busy_q <= busy_d;
    end
  end

  // Register bus answer registers
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end
  // Link pins and bus answer come straight from flops
  assign link.sclk = sclk_q;
  assign link.sync_n = sync_n_q;
  assign link.serial_data_input = sdi_q;
  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
endmodule

// *** sim/dac_serial_word_and_coding_checker.sv ***
// Checker for the serial link between the host end and the converter end.
// Assumes it sits beside the link interface in the bench top, on the host clock.
module dac_serial_word_and_coding_checker (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic serial_data_input,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic [4:0] falls_q;
  logic [4:0] falls_d;
  logic fall;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // Count link clock falls inside a frame; a high frame line clears it
  assign fall = sclk_q && !sclk;
  always_comb begin
    falls_d = falls_q;
    if (sync_n) begin
      falls_d = 5'h00;
    end else if (fall) begin
      falls_d = falls_q + 5'h01;
    end
  end
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      sclk_q <= 1'b1;
      falls_q <= 5'h00;
    end else begin
      sclk_q <= sclk;
      falls_q <= falls_d;
    end
  end
  AST_IDLE_HIGH: assert property (sync_n |-> sclk)
    else $error("link clock not high between frames");
  AST_REST_ZERO: assert property (fall && falls_q == 5'h01 |-> !serial_data_input)
    else $error("reserved bit sent as one");
  AST_WORD_LEN: assert property ($rose(sync_n) |-> falls_q == 5'h18)
    else $error("frame did not carry 24 bits");
  AST_FRAME_SPAN: assert property ($fell(sync_n) |-> ##[191:193] $rose(sync_n))
    else $error("frame length wrong");
  AST_DATA_STEADY: assert property (fall |-> $stable(serial_data_input))
    else $error("data moved at the sampling edge");
  AST_HIGH_HALF: assert property ($rose(sclk) && !sync_n |-> sclk[*4])
    else $error("link clock high half too short");
  AST_LOW_HALF: assert property (fall |-> (!sclk && !sync_n)[*4])
    else $error("link clock low half wrong");
  AST_SYNC_START: assert property ($fell(sync_n) |-> sclk[*4])
    else $error("frame opened without clock high");
  // Main scenarios: whole frames, ones on the wire, readback traffic
  cover property ($rose(sync_n));
  cover property (fall && serial_data_input);
  cover property (fall && sdo);
endmodule

// *** sim/dac_serial_word_and_coding_tb.sv ***
// Bench: host end drives the device end over the link; APB tasks give the orders.
// Assumes the design package, interface and both ends are compiled first.
module dac_serial_word_and_coding_tb
  import dac_word_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin = 1'b1;
  logic [11:0] code_a, code_b;
  logic bip_a, bip_b, done;
  logic [2:0] rng_a, rng_b;
  logic [15:0] power, ctl;
  logic [31:0] r;
  logic e;
  int mismatches = 0;
  int total_checks = 0;
  int frames = 0;
  int dones = 0;
  dac_link_if link();
  dac_word_host u_dac_word_host (.i_clock(i_clock), .i_reset(i_reset), .link(link),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
  dac_word_device u_dac_word_device (.i_clock(i_clock), .i_reset(i_reset), .link(link),
    .i_coding_select_pin(pin), .o_code_a(code_a), .o_code_b(code_b), .o_bipolar_a(bip_a),
    .o_bipolar_b(bip_b), .o_range_a(rng_a), .o_range_b(rng_b), .o_power(power),
    .o_control(ctl), .o_word_done(done));
  dac_serial_word_and_coding_checker u_checker (.i_clock(i_clock), .i_reset(i_reset),
    .sclk(link.sclk), .sync_n(link.sync_n), .serial_data_input(link.serial_data_input),
    .sdo(link.sdo));
  // Clock and completion pulse counter
  always #10 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    if (done === 1'b1) begin
      dones++;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; pready and the answer are taken at the rising edge that completes it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Send a word, then poll busy; only the watchdog ends a hang
  task automatic send(input logic [23:0] w);
    apb(1'b1, OFF_CMD, {8'h00, w});
    frames++;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
    end while (r[0] !== 1'b0);
    repeat (8) @(posedge i_clock);
  endtask
  task automatic wrap_up();
    $display("frames=%0d dones=%0d checks=%0d mismatches=%0d", frames, dones,
      total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    // Range to both channels, then channel B alone back to unipolar
    send(24'h0C0004);
    chk(32'(rng_a), 32'h4);
    chk(32'(rng_b), 32'h4);
    chk(32'(bip_b), 32'h1);
    chk(32'(bip_a), 32'h1);
    send(24'h0A0000);
    chk(32'(rng_b), 32'h0);
    chk(32'(bip_b), 32'h0);
    chk(32'(rng_a), 32'h4);
    $display("range test done");
    // Offset binary on A; the low nibble must be dropped
    pin <= 1'b1;
    send(24'h00800F);
    chk(32'(code_a), 32'h800);
    send(24'h00FFF0);
    chk(32'(code_a), 32'hFFF);
    // Twos complement on A, unipolar on B with the same pin level
    pin <= 1'b0;
    send(24'h007FF0);
    chk(32'(code_a), 32'hFFF);
    send(24'h00FFF0);
    chk(32'(code_a), 32'h7FF);
    send(24'h020FFF);
    chk(32'(code_b), 32'h0FF);
    send(24'h028000);
    chk(32'(code_b), 32'h800);
    $display("coding test done");
    // Power and control targets, then readback of range A; the fourth word has the reserved bit set
    send(24'h100015);
    chk(32'(power), 32'h15);
    send(24'h180123);
    chk(32'(ctl), 32'h0123);
    send(24'h880000);
    send(24'hC80000);
    apb(1'b0, OFF_RDATA, 32'h0);
    chk({8'h00, r[23:0]}, 32'h880004);
    apb(1'b0, OFF_CMD, 32'h0);
    chk(r, 32'h00880000);
    $display("readback test done");
    // Unmapped offset is refused; every frame produced one completion pulse
    apb(1'b0, 8'h0C, 32'h0);
    chk(32'(e), 32'h1);
    chk(32'(dones), 32'(frames));
    $display("bus test done");
    wrap_up();
  end
endmodule
